/* File: logic/pchp_pkg.sv */
package pchp_pkg;

    localparam int CLK_PERIOD_NS = 50;

    // port offsets on the two low address lines
    localparam logic [1:0] PORT_DATA = 2'h0;
    localparam logic [1:0] PORT_STATUS = 2'h1;
    localparam logic [1:0] PORT_CONFIG = 2'h2;
    localparam logic [1:0] PORT_CONTROL = 2'h3;

    // hardware status bit positions
    localparam int STAT_UC_HI = 7;
    localparam int STAT_UC_LO = 6;
    localparam int STAT_IRQ = 5;
    localparam int STAT_DRQ = 4;
    localparam int STAT_BUSY = 3;
    localparam int STAT_CD = 2;
    localparam int STAT_IO = 1;
    localparam int STAT_REQ = 0;

    // control port bit positions
    localparam int CTRL_DMA_EN_BIT = 0;
    localparam int CTRL_IRQ_EN_BIT = 1;

    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // board reset pulse, least time
    localparam int BOARD_RESET_NS = 1000;
    localparam int BOARD_RESET_CYC =
        (BOARD_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 8;

    // slave mode strobe, least time; must cover the data synchroniser
    localparam int SLAVE_STROBE_NS = 150;
    localparam int SLAVE_STROBE_CYC =
        (SLAVE_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STB_CNT_W = 4;

    localparam int SLAVE_AW = 5;

    typedef struct packed {
        logic sel_n;
        logic rd_n;
        logic wr_n;
        logic a9;
        logic a2;
        logic a1;
        logic a0;
        logic [7:0] data;
    } pchp_pins_t;

    typedef struct packed {
        logic valid;
        logic [7:0] data;
    } pchp_byte_t;

    typedef enum {
        SLV_IDLE,
        SLV_STROBE,
        SLV_DONE
    } pchp_slave_state_t;

endpackage : pchp_pkg

/* File: logic/pchp_sync.sv */
`timescale 1ns/10ps
// two-flop synchroniser for the asynchronous host pins
module pchp_sync (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire pchp_pkg::pchp_pins_t i_pins,
    output pchp_pkg::pchp_pins_t o_pins
);
    import pchp_pkg::*;

    pchp_pins_t meta_r;
    pchp_pins_t sync_r;

    // strobes idle high, so reset to the inactive pin levels
    localparam pchp_pins_t PINS_IDLE = '{sel_n: 1'b1, rd_n: 1'b1,
        wr_n: 1'b1, a9: 1'b0, a2: 1'b0, a1: 1'b0, a0: 1'b0,
        data: BYTE_ZERO};

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            meta_r <= PINS_IDLE;
            sync_r <= PINS_IDLE;
        end else if (i_clk_en) begin
            meta_r <= i_pins;
            sync_r <= meta_r;
        end
    end

    assign o_pins = sync_r;

endmodule : pchp_sync

/* File: logic/pchp_irq_dma.sv */
`timescale 1ns/10ps
// host interrupt flip-flop and dma request gating
module pchp_irq_dma (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic i_wr_ctrl,
    input wire logic [7:0] i_wdata,
    input wire logic i_board_reset,
    input wire logic i_irq_event,
    input wire logic i_dma_pending_flag,
    output logic o_irq_pending,
    output logic o_irq_line,
    output logic o_irq_oe_n,
    output logic o_dma_line,
    output logic o_irq_enable,
    output logic o_dma_enable
);
    import pchp_pkg::*;

    logic irq_en_r;
    logic dma_en_r;
    logic irq_ff_r;
    logic dma_line_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_en_r <= 1'b0;
            dma_en_r <= 1'b0;
        end else if (i_clk_en) begin
            if (i_board_reset) begin
                irq_en_r <= 1'b0;
                dma_en_r <= 1'b0;
            end else if (i_wr_ctrl) begin
                irq_en_r <= i_wdata[CTRL_IRQ_EN_BIT];
                dma_en_r <= i_wdata[CTRL_DMA_EN_BIT];
            end
        end
    end

    // event only latches while enabled; disable or reset wipes it
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            irq_ff_r <= 1'b0;
        end else if (i_clk_en) begin
            if (i_board_reset || !irq_en_r) begin
                irq_ff_r <= 1'b0;
            end else if (i_irq_event) begin
                irq_ff_r <= 1'b1;
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            dma_line_r <= 1'b0;
        end else if (i_clk_en) begin
            dma_line_r <= i_dma_pending_flag && dma_en_r && !i_board_reset;
        end
    end

    assign o_irq_pending = irq_ff_r && irq_en_r;
    assign o_irq_line = irq_ff_r && irq_en_r;
    assign o_irq_oe_n = !irq_en_r;
    assign o_dma_line = dma_line_r;
    assign o_irq_enable = irq_en_r;
    assign o_dma_enable = dma_en_r;

endmodule : pchp_irq_dma

/* File: logic/pchp_host_port.sv */
`timescale 1ns/10ps
module pchp_host_port (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_clk_en,
    input wire logic i_host_port_select_n,
    input wire logic i_host_rd_n,
    input wire logic i_host_wr_n,
    input wire logic i_host_addr_bit_nine,
    input wire logic i_host_addr_bit_two,
    input wire logic i_host_addr_bit_one,
    input wire logic i_host_addr_bit_zero,
    input wire logic [7:0] i_host_data,
    output logic [7:0] o_host_data,
    output logic o_host_data_oe_n,
    output logic o_host_interrupt_line,
    output logic o_host_interrupt_line_oe_n,
    output logic o_host_dma_request_line,
    input wire logic i_bus_flavor_bit,
    input wire logic i_slave_mode,
    input wire logic i_reset_enable,
    input wire logic [1:0] i_uc_status_hi,
    input wire logic i_cmd_status_flag,
    input wire logic i_host_reads_flag,
    input wire logic [7:0] i_drive_config,
    input wire logic i_command_busy_flag,
    input wire logic i_irq_event,
    input wire logic i_dma_pending_flag,
    input wire logic i_local_cpu_int_clear,
    output logic o_local_cpu_interrupt,
    output logic o_board_reset,
    input wire logic [7:0] i_buf_rd_data,
    input wire logic i_buf_rd_valid,
    output logic o_buf_rd_take,
    output pchp_pkg::pchp_byte_t o_buf_wr,
    input wire logic i_buf_wr_ready,
    input wire logic i_slave_start,
    input wire logic i_slave_write,
    input wire logic [pchp_pkg::SLAVE_AW-1:0] i_slave_reg_addr,
    input wire logic [7:0] i_slave_wdata,
    output logic [7:0] o_slave_rdata,
    output logic o_slave_done,
    output logic [pchp_pkg::SLAVE_AW-1:0] o_slave_reg_addr,
    output logic o_slave_rd_n,
    output logic o_slave_wr_n
);
    import pchp_pkg::*;

    function automatic logic port_is(input pchp_pins_t p,
                                     input logic [1:0] off);
        // high address lines do not take part in the decode
        port_is = ({p.a1, p.a0} == off);
    endfunction : port_is

    ////////////////////////////////////////////////////////////////////
    // pin synchronisation and strobe edges

    pchp_pins_t pins_raw;
    pchp_pins_t pins;
    logic rd_act;
    logic wr_act;
    logic rd_act_r;
    logic wr_act_r;
    logic rd_start;
    logic rd_end;
    logic wr_end;
    logic port_on;
    pchp_pins_t wr_hold_r;

    assign pins_raw = '{sel_n: i_host_port_select_n, rd_n: i_host_rd_n,
        wr_n: i_host_wr_n, a9: i_host_addr_bit_nine,
        a2: i_host_addr_bit_two, a1: i_host_addr_bit_one,
        a0: i_host_addr_bit_zero, data: i_host_data};

    pchp_sync u_sync (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_pins(pins_raw),
        .o_pins(pins)
    );

    // AT map and slave mode live elsewhere; this map sleeps then
    assign port_on = !i_bus_flavor_bit && !i_slave_mode;
    assign rd_act = port_on && !pins.sel_n && !pins.rd_n;
    assign wr_act = port_on && !pins.sel_n && !pins.wr_n;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_act_r <= 1'b0;
            wr_act_r <= 1'b0;
        end else if (i_clk_en) begin
            rd_act_r <= rd_act;
            wr_act_r <= wr_act;
        end
    end

    assign rd_start = rd_act && !rd_act_r;
    assign rd_end = !rd_act && rd_act_r;
    assign wr_end = !wr_act && wr_act_r;

    // address and data are taken while the strobe is still low
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            wr_hold_r <= '0;
        end else if (i_clk_en && wr_act) begin
            wr_hold_r <= pins;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // board reset and microcontroller interrupt

    logic [RST_CNT_W-1:0] rst_cnt_r;
    logic board_reset_r;
    logic local_int_r;
    logic reset_hit;
    logic select_hit;

    assign reset_hit = wr_end && port_is(wr_hold_r, PORT_STATUS);
    assign select_hit = wr_end && port_is(wr_hold_r, PORT_CONFIG);

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_cnt_r <= '0;
            board_reset_r <= 1'b0;
        end else if (i_clk_en) begin
            if (reset_hit && i_reset_enable) begin
                rst_cnt_r <= RST_CNT_W'(BOARD_RESET_CYC - 1);
                board_reset_r <= 1'b1;
            end else if (rst_cnt_r != '0) begin
                rst_cnt_r <= rst_cnt_r - 1'b1;
            end else begin
                board_reset_r <= 1'b0;
            end
        end
    end

    // sticky until firmware clears it; a new write wins over the clear
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            local_int_r <= 1'b0;
        end else if (i_clk_en) begin
            if ((reset_hit && !i_reset_enable) || select_hit) begin
                local_int_r <= 1'b1;
            end else if (i_local_cpu_int_clear) begin
                local_int_r <= 1'b0;
            end
        end
    end

    assign o_board_reset = board_reset_r;
    assign o_local_cpu_interrupt = local_int_r;

    ////////////////////////////////////////////////////////////////////
    // dma and interrupt control

    logic irq_pending;
    logic dma_line;

    pchp_irq_dma u_irq_dma (
        .i_clk(i_clk),
        .i_resetn(i_resetn),
        .i_clk_en(i_clk_en),
        .i_wr_ctrl(wr_end && port_is(wr_hold_r, PORT_CONTROL)),
        .i_wdata(wr_hold_r.data),
        .i_board_reset(board_reset_r),
        .i_irq_event(i_irq_event),
        .i_dma_pending_flag(i_dma_pending_flag),
        .o_irq_pending(irq_pending),
        .o_irq_line(o_host_interrupt_line),
        .o_irq_oe_n(o_host_interrupt_line_oe_n),
        .o_dma_line(dma_line),
        .o_irq_enable(),
        .o_dma_enable()
    );

    assign o_host_dma_request_line = dma_line;

    ////////////////////////////////////////////////////////////////////
    // hardware status

    logic [7:0] status;
    logic req_ready;

    // ready follows whichever buffer side the host is told to use
    assign req_ready = i_host_reads_flag ? i_buf_rd_valid
                                         : i_buf_wr_ready;

    always_comb begin
        status = BYTE_ZERO;
        status[STAT_UC_HI] = i_uc_status_hi[1];
        status[STAT_UC_LO] = i_uc_status_hi[0];
        status[STAT_IRQ] = irq_pending;
        status[STAT_DRQ] = dma_line;
        status[STAT_BUSY] = i_command_busy_flag || board_reset_r;
        status[STAT_CD] = i_cmd_status_flag;
        status[STAT_IO] = i_host_reads_flag;
        status[STAT_REQ] = req_ready && !board_reset_r;
    end

    ////////////////////////////////////////////////////////////////////
    // host reads

    logic [7:0] rd_data_r;
    logic rd_drive_r;
    logic rd_from_buf_r;

    // data is captured once at strobe start; a held read sees no change
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rd_data_r <= BYTE_ZERO;
            rd_drive_r <= 1'b0;
            rd_from_buf_r <= 1'b0;
        end else if (i_clk_en) begin
            if (rd_start) begin
                rd_drive_r <= !port_is(pins, PORT_CONTROL);
                rd_from_buf_r <= port_is(pins, PORT_DATA);
                unique case ({pins.a1, pins.a0})
                    PORT_DATA: rd_data_r <= i_buf_rd_data;
                    PORT_STATUS: rd_data_r <= status;
                    PORT_CONFIG: rd_data_r <= i_drive_config;
                    PORT_CONTROL: rd_data_r <= BYTE_ZERO;
                endcase
            end else if (!rd_act) begin
                rd_drive_r <= 1'b0;
            end
        end
    end

    // buffer advances only at the end of a data-port read
    assign o_buf_rd_take = i_clk_en && rd_end && rd_from_buf_r;

    ////////////////////////////////////////////////////////////////////
    // host writes into the buffer

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            o_buf_wr <= '0;
        end else if (i_clk_en) begin
            o_buf_wr.valid <= wr_end && port_is(wr_hold_r, PORT_DATA);
            if (wr_end) begin
                o_buf_wr.data <= wr_hold_r.data;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // slave host mode: microcontroller drives a peripheral

    pchp_slave_state_t slv_state_r;
    logic [STB_CNT_W-1:0] stb_cnt_r;
    logic slv_write_r;
    logic [7:0] slv_wdata_r;

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            slv_state_r <= SLV_IDLE;
            stb_cnt_r <= '0;
            slv_write_r <= 1'b0;
            slv_wdata_r <= BYTE_ZERO;
            o_slave_reg_addr <= '0;
            o_slave_rdata <= BYTE_ZERO;
        end else if (i_clk_en) begin
            unique case (slv_state_r)
                SLV_IDLE: begin
                    if (i_slave_mode && i_slave_start) begin
                        slv_state_r <= SLV_STROBE;
                        stb_cnt_r <= STB_CNT_W'(SLAVE_STROBE_CYC - 1);
                        slv_write_r <= i_slave_write;
                        slv_wdata_r <= i_slave_wdata;
                        o_slave_reg_addr <= i_slave_reg_addr;
                    end
                end
                SLV_STROBE: begin
                    if (stb_cnt_r != '0) begin
                        stb_cnt_r <= stb_cnt_r - 1'b1;
                    end else begin
                        // synchronised data lags the pins by two clocks
                        if (!slv_write_r) begin
                            o_slave_rdata <= pins.data;
                        end
                        slv_state_r <= SLV_DONE;
                    end
                end
                SLV_DONE: begin
                    slv_state_r <= SLV_IDLE;
                end
            endcase
        end
    end

    assign o_slave_done = slv_state_r == SLV_DONE;
    assign o_slave_rd_n = !(slv_state_r == SLV_STROBE && !slv_write_r);
    assign o_slave_wr_n = !(slv_state_r == SLV_STROBE && slv_write_r);

    ////////////////////////////////////////////////////////////////////
    // shared data pins

    logic slv_drive;

    assign slv_drive = slv_state_r == SLV_STROBE && slv_write_r;
    assign o_host_data = slv_drive ? slv_wdata_r : rd_data_r;
    assign o_host_data_oe_n = !((rd_drive_r && rd_act) || slv_drive);

endmodule : pchp_host_port

/* File: tb/pchp_host_port_sva.sv */
`timescale 1ns/10ps
module pchp_host_port_sva (
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_host_port_select_n,
    input wire logic i_host_rd_n,
    input wire logic i_host_wr_n,
    input wire logic i_host_addr_bit_one,
    input wire logic i_host_addr_bit_zero,
    input wire logic [7:0] i_host_data,
    input wire logic i_bus_flavor_bit,
    input wire logic i_slave_mode,
    input wire logic i_reset_enable,
    input wire logic i_irq_event,
    input wire logic i_dma_pending_flag,
    input wire logic o_host_data_oe_n,
    input wire logic o_host_interrupt_line,
    input wire logic o_host_interrupt_line_oe_n,
    input wire logic o_host_dma_request_line,
    input wire logic o_local_cpu_interrupt,
    input wire logic o_board_reset
);
    import pchp_pkg::*;
    logic [1:0] off;
    logic ok;
    logic [7:0] rst_cnt_r;
    assign off = {i_host_addr_bit_one, i_host_addr_bit_zero};
    assign ok = !i_host_port_select_n && !i_bus_flavor_bit && !i_slave_mode;
    // counts how long the board reset pulse has stood
    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            rst_cnt_r <= 8'h00;
        end else if (o_board_reset) begin
            rst_cnt_r <= rst_cnt_r + 8'h01;
        end else begin
            rst_cnt_r <= 8'h00;
        end
    end
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_resetn);
    ////////////////////////////////////////////////////////////////////////
    property p_irq_float;
        o_host_interrupt_line |-> !o_host_interrupt_line_oe_n;
    endproperty
    a_irq_float: assert property (p_irq_float)
        else $error("interrupt raised while line floated");
    property p_rst_clears;
        o_board_reset [*3] |-> o_host_interrupt_line_oe_n
            && !o_host_interrupt_line && !o_host_dma_request_line;
    endproperty
    a_rst_clears: assert property (p_rst_clears)
        else $error("board reset left a request standing");
    property p_dma_gate;
        o_host_dma_request_line |-> $past(i_dma_pending_flag)
            && !$past(o_board_reset);
    endproperty
    a_dma_gate: assert property (p_dma_gate)
        else $error("dma request without pending flag");
    property p_irq_set;
        i_irq_event && !o_host_interrupt_line_oe_n && !o_board_reset
            |-> ##[1:2] o_host_interrupt_line;
    endproperty
    a_irq_set: assert property (p_irq_set)
        else $error("enabled interrupt event not raised");
    property p_irq_off;
        ok && !i_host_wr_n && off == PORT_CONTROL
            && !i_host_data[CTRL_IRQ_EN_BIT] ##1 i_host_wr_n
            |-> ##[1:6] o_host_interrupt_line_oe_n;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt line not floated on disable");
    property p_rst_go;
        ok && i_reset_enable && !i_host_wr_n && off == PORT_STATUS
            ##1 i_host_wr_n |-> ##[1:6] o_board_reset;
    endproperty
    a_rst_go: assert property (p_rst_go)
        else $error("board reset not raised");
    property p_rst_len;
        $fell(o_board_reset) |-> rst_cnt_r == BOARD_RESET_CYC;
    endproperty
    a_rst_len: assert property (p_rst_len)
        else $error("board reset pulse has wrong length");
    property p_uc_rst;
        ok && !i_reset_enable && !i_host_wr_n && off == PORT_STATUS
            ##1 i_host_wr_n |-> ##[1:6] o_local_cpu_interrupt;
    endproperty
    a_uc_rst: assert property (p_uc_rst)
        else $error("local interrupt missing on disabled reset");
    property p_uc_sel;
        ok && !i_host_wr_n && off == PORT_CONFIG
            ##1 i_host_wr_n |-> ##[1:6] o_local_cpu_interrupt;
    endproperty
    a_uc_sel: assert property (p_uc_sel)
        else $error("local interrupt missing on select write");
    property p_rd_drive;
        $fell(o_host_data_oe_n) |-> $past(ok) && !$past(i_host_rd_n)
            && $past(off) != PORT_CONTROL;
    endproperty
    a_rd_drive: assert property (p_rd_drive)
        else $error("data bus driven without a valid read");
    c_rst: cover property ($rose(o_board_reset));
    c_irq: cover property ($rose(o_host_interrupt_line));
    c_uc: cover property ($rose(o_local_cpu_interrupt));
endmodule : pchp_host_port_sva

/* File: tb/pchp_host_cpu.sv */
`timescale 1ns/10ps
module pchp_host_cpu (
    input wire logic i_clk,
    input wire logic [7:0] i_dev_data,
    input wire logic i_dev_data_oe_n,
    output logic o_sel_n,
    output logic o_rd_n,
    output logic o_wr_n,
    output logic o_a9,
    output logic o_a2,
    output logic o_a1,
    output logic o_a0,
    output logic [7:0] o_bus
);
    logic [9:0] addr_r;
    logic [7:0] drv_r;
    logic [7:0] last_r;
    logic drv_en_r;
    logic cyc_r;
    initial begin
        {addr_r, drv_r, last_r, drv_en_r, cyc_r} = '0;
        {o_rd_n, o_wr_n} = 2'h3;
    end
    // primary block 320-323 or secondary block 324-327
    assign o_sel_n = !(cyc_r && addr_r[9:3] == 7'h64);
    assign {o_a9, o_a2, o_a1, o_a0} = {addr_r[9], addr_r[2:0]};
    // no keeper on the bus: a released bus must not show stale data
    always_comb begin
        if (drv_en_r) begin
            o_bus = drv_r;
        end else if (!i_dev_data_oe_n) begin
            o_bus = i_dev_data;
        end else begin
            o_bus = ~last_r;
        end
    end
    always @(posedge i_clk) last_r <= o_bus;
    ////////////////////////////////////////////////////////////////////////
    task automatic wait_cyc(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : wait_cyc
    // strobe held 5 clocks, released 2 clocks before select, then idle
    task automatic cycle(input logic [9:0] a, input logic wr,
                         input logic [7:0] wd, output logic [7:0] rd,
                         output logic drv);
        addr_r = a;
        cyc_r = 1'b1;
        drv_r = wd;
        drv_en_r = wr;
        o_wr_n = !wr;
        o_rd_n = wr;
        wait_cyc(5);
        rd = o_bus;
        drv = !i_dev_data_oe_n;
        {o_rd_n, o_wr_n} = 2'h3;
        wait_cyc(2);
        {cyc_r, drv_en_r} = 2'h0;
        wait_cyc(3);
    endtask : cycle
endmodule : pchp_host_cpu

/* File: tb/pchp_host_port_bench.sv */
`timescale 1ns/10ps
module pchp_host_port_bench;
    import pchp_pkg::*;
    logic i_clk, i_resetn, i_clk_en, i_host_port_select_n, i_host_rd_n;
    logic i_host_wr_n, i_host_addr_bit_nine, i_host_addr_bit_two;
    logic i_host_addr_bit_one, i_host_addr_bit_zero, o_host_data_oe_n;
    logic [7:0] i_host_data, o_host_data, i_drive_config, i_buf_rd_data;
    logic o_host_interrupt_line, o_host_interrupt_line_oe_n;
    logic o_host_dma_request_line, i_bus_flavor_bit, i_slave_mode;
    logic i_reset_enable, i_cmd_status_flag, i_host_reads_flag;
    logic [1:0] i_uc_status_hi;
    logic i_command_busy_flag, i_irq_event, i_dma_pending_flag;
    logic i_local_cpu_int_clear, o_local_cpu_interrupt, o_board_reset;
    logic i_buf_rd_valid, o_buf_rd_take, i_buf_wr_ready, i_slave_start;
    logic i_slave_write, o_slave_done, o_slave_rd_n, o_slave_wr_n;
    logic [SLAVE_AW-1:0] i_slave_reg_addr, o_slave_reg_addr;
    logic [7:0] i_slave_wdata, o_slave_rdata, rv, wr_last;
    pchp_byte_t o_buf_wr;
    logic rdrv;
    int mismatches, comparisons, takes, wrs, cycles;
    pchp_host_port dut (.*);
    pchp_host_cpu u_host (.i_clk(i_clk), .i_dev_data(o_host_data),
        .i_dev_data_oe_n(o_host_data_oe_n), .o_sel_n(i_host_port_select_n),
        .o_rd_n(i_host_rd_n), .o_wr_n(i_host_wr_n),
        .o_a9(i_host_addr_bit_nine), .o_a2(i_host_addr_bit_two),
        .o_a1(i_host_addr_bit_one), .o_a0(i_host_addr_bit_zero),
        .o_bus(i_host_data));
    initial begin
        i_clk = 1'b0;
        forever #25 i_clk = ~i_clk;
    end
    // buffer side monitor and hang guard
    always @(negedge i_clk) begin
        cycles++;
        if (o_buf_rd_take === 1'b1) takes++;
        if (o_buf_wr.valid === 1'b1) begin
            wrs++;
            wr_last = o_buf_wr.data;
        end
        if (cycles == 6000) begin
            mismatches++;
            finish_test();
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : finish_test
    task automatic hrd(input logic [9:0] a);
        u_host.cycle(a, 1'b0, 8'h00, rv, rdrv);
    endtask : hrd
    task automatic hwr(input logic [9:0] a, input logic [7:0] d);
        u_host.cycle(a, 1'b1, d, rv, rdrv);
    endtask : hwr
    task automatic pulse(ref logic s);
        s = 1'b1;
        u_host.wait_cyc(1);
        s = 1'b0;
        u_host.wait_cyc(3);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////
    task automatic t_status();
        int t0 = takes;
        {i_uc_status_hi, i_cmd_status_flag, i_host_reads_flag} = 4'hb;
        {i_command_busy_flag, i_buf_rd_valid, i_buf_wr_ready} = 3'h6;
        hrd(10'h325);
        check(rv, 8'h8f);
        {i_uc_status_hi, i_cmd_status_flag, i_host_reads_flag} = 4'h4;
        i_command_busy_flag = 1'b0;
        hrd(10'h321);
        check(rv, 8'h40);
        check(8'(takes - t0), 8'h00);
    endtask : t_status
    task automatic t_data();
        int t0 = takes;
        int w0 = wrs;
        {i_host_reads_flag, i_buf_rd_data} = {1'b1, 8'h5a};
        hrd(10'h321);
        check(8'(rv[STAT_REQ]), 8'h01);
        hrd(10'h320);
        check(rv, 8'h5a);
        check(8'(takes - t0), 8'h01);
        {i_host_reads_flag, i_buf_wr_ready} = 2'h1;
        hwr(10'h324, 8'ha7);
        hwr(10'h320, 8'h3c);
        check(8'(wrs - w0), 8'h02);
        check(wr_last, 8'h3c);
    endtask : t_data
    task automatic t_config();
        i_drive_config = 8'hc3;
        hrd(10'h322);
        check(rv, 8'hc3);
        check(8'(o_local_cpu_interrupt), 8'h00);
        hwr(10'h326, 8'h00);
        check(8'(o_local_cpu_interrupt), 8'h01);
        pulse(i_local_cpu_int_clear);
        hrd(10'h323);
        check(8'(rdrv), 8'h00);
    endtask : t_config
    task automatic t_ctrl();
        hwr(10'h323, 8'h03);
        pulse(i_irq_event);
        i_dma_pending_flag = 1'b1;
        hrd(10'h321);
        check(8'({rv[STAT_IRQ], rv[STAT_DRQ]}), 8'h03);
        check(8'(o_host_dma_request_line), 8'h01);
        hwr(10'h323, 8'h01);
        hrd(10'h321);
        check(8'({rv[STAT_IRQ], rv[STAT_DRQ]}), 8'h01);
        pulse(i_irq_event);
        hwr(10'h327, 8'h02);
        check(8'({o_host_interrupt_line, o_host_dma_request_line}), 8'h00);
        check(8'(o_host_interrupt_line_oe_n), 8'h00);
        pulse(i_irq_event);
        i_resetn = 1'b0;
        u_host.wait_cyc(2);
        check(8'(o_host_interrupt_line_oe_n), 8'h01);
        i_resetn = 1'b1;
        u_host.wait_cyc(2);
    endtask : t_ctrl
    task automatic t_reset_port();
        hwr(10'h323, 8'h03);
        {i_reset_enable, i_host_reads_flag, i_buf_rd_valid} = 3'h7;
        hwr(10'h321, 8'hff);
        check(8'(o_board_reset), 8'h01);
        hrd(10'h321);
        check(8'({rv[STAT_BUSY], rv[STAT_REQ]}), 8'h02);
        u_host.wait_cyc(BOARD_RESET_CYC);
        pulse(i_irq_event);
        check(8'({o_board_reset, o_host_interrupt_line}), 8'h00);
        check(8'(o_host_dma_request_line), 8'h00);
        i_reset_enable = 1'b0;
        hwr(10'h325, 8'h00);
        check(8'({o_board_reset, o_local_cpu_interrupt}), 8'h01);
        pulse(i_local_cpu_int_clear);
    endtask : t_reset_port
    task automatic t_flavor();
        int t0 = takes;
        i_bus_flavor_bit = 1'b1;
        hwr(10'h322, 8'h00);
        hrd(10'h320);
        check(8'({rdrv, o_local_cpu_interrupt}), 8'h00);
        {i_bus_flavor_bit, i_slave_mode} = 2'h1;
        hwr(10'h322, 8'h00);
        check(8'(o_local_cpu_interrupt), 8'h00);
        check(8'(takes - t0), 8'h00);
        {u_host.drv_en_r, u_host.drv_r, i_slave_reg_addr} = 14'h32db;
        pulse(i_slave_start);
        check(o_slave_rdata, 8'h96);
        check(8'({o_slave_done, o_slave_rd_n, o_slave_wr_n}), 8'h07);
        check(8'(o_slave_reg_addr), 8'h1b);
        i_slave_mode = 1'b0;
    endtask : t_flavor
    initial begin
        {i_resetn, i_drive_config, i_buf_rd_data, i_bus_flavor_bit} = '0;
        {i_slave_mode, i_reset_enable, i_uc_status_hi, i_irq_event} = '0;
        {i_cmd_status_flag, i_host_reads_flag, i_command_busy_flag} = '0;
        {i_dma_pending_flag, i_local_cpu_int_clear, i_buf_rd_valid} = '0;
        {i_buf_wr_ready, i_slave_start, i_slave_write} = '0;
        {i_slave_reg_addr, i_slave_wdata} = '0;
        i_clk_en = 1'b1;
        u_host.wait_cyc(5);
        i_resetn = 1'b1;
        u_host.wait_cyc(2);
        t_status();
        t_data();
        t_config();
        t_ctrl();
        t_reset_port();
        t_flavor();
        finish_test();
    end
endmodule : pchp_host_port_bench
bind pchp_host_port pchp_host_port_sva u_sva (.*);
